// ===== pws_pkg.sv
/*
  Shared constants and types for the pushbutton wiper stepper.
  Assumes a single 250 MHz clock; all times below are converted to cycles.
*/
package pws_pkg;

    // ------------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------------
    localparam int CLK_HZ     = 250_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1_000;

    localparam int CONTACT_MS = 1;     // contact qualify / release time
    localparam int DIGITAL_US = 1;     // step input least low time
    localparam int HOLD_MS    = 1000;  // hold before auto-repeat
    localparam int REPEAT_MS  = 100;   // auto-repeat interval
    localparam int IDLE_MS    = 1000;  // inactivity before reversal
    localparam int STORE_MS   = 2000;  // stable time before a store

    localparam int CONTACT_CYC = CONTACT_MS * CLK_PER_MS;
    localparam int DIGITAL_CYC = DIGITAL_US * CLK_PER_US;
    localparam int HOLD_CYC    = HOLD_MS * CLK_PER_MS;
    localparam int REPEAT_CYC  = REPEAT_MS * CLK_PER_MS;
    localparam int IDLE_CYC    = IDLE_MS * CLK_PER_MS;
    localparam int STORE_CYC   = STORE_MS * CLK_PER_MS;

    // ------------------------------------------------------------------
    // widths, positions and reset values
    // ------------------------------------------------------------------
    localparam int         WIPER_W   = 6;
    localparam int         CNT_W     = 32;
    localparam int         NCH       = 3;
    localparam int         CH_UP     = 0;
    localparam int         CH_DOWN   = 1;
    localparam int         CH_STEP   = 2;
    localparam int         STORE_BIT = 3;
    localparam logic [5:0] WIPER_MIN = 6'h00;
    localparam logic [5:0] WIPER_MAX = 6'h3F;
    localparam logic [5:0] WIPER_RST = 6'h00;

    typedef enum {SEL_NONE, SEL_UP, SEL_DOWN, SEL_STEP} pws_sel_e;

    typedef struct packed {
        logic                      booted;
        logic                      single;
        logic                      dir_up;
        logic                      moved;
        logic                      first_done;
        logic                      nv_write;
        logic [WIPER_W-1:0]        wiper;
        logic [WIPER_W-1:0]        stored;
        logic [WIPER_W-1:0]        nv_data;
        logic [NCH-1:0]            pressed;
        logic [NCH-1:0]            pend;
        logic [NCH-1:0][CNT_W-1:0] lvl_cnt;
        logic [NCH-1:0][CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0]          idle_cnt;
        logic [CNT_W-1:0]          stable_cnt;
    } pws_state_s;

endpackage : pws_pkg

// ===== pws_stepper.sv
/*
  Wiper stepping control: qualifies the three active-low control inputs,
  steps a 6-bit wiper, handles one/two button modes, direction reversal
  and nonvolatile store requests.
  Assumes inputs synchronous to clk_in, a nonvolatile cell that presents
  the saved wiper on nv_data_in at reset release and accepts one-cycle
  write pulses, and a strap level telling whether down contact is tied high.
*/
`timescale 1ns/1ps
module pws_stepper #(
    parameter int CONTACT_CYC = pws_pkg::CONTACT_CYC,
    parameter int HOLD_CYC    = pws_pkg::HOLD_CYC,
    parameter int REPEAT_CYC  = pws_pkg::REPEAT_CYC,
    parameter int IDLE_CYC    = pws_pkg::IDLE_CYC,
    parameter int STORE_CYC   = pws_pkg::STORE_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       up_contact_in,
    input  wire logic       down_contact_in,
    input  wire logic       step_in,
    input  wire logic       down_strap_in,
    input  wire logic [5:0] nv_data_in,
    output logic      [5:0] wiper_out,
    output logic            single_mode_out,
    output logic            dir_up_out,
    output logic            nv_write_out,
    output logic      [5:0] nv_data_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pws_pkg::pws_state_s st;
    pws_pkg::pws_state_s next_st;
    pws_pkg::pws_sel_e   sel;
    logic [pws_pkg::NCH-1:0] raw;
    logic [pws_pkg::NCH-1:0] served;
    logic [pws_pkg::CNT_W-1:0] qual;
    logic                 sg_step;
    logic                 go_up;
    logic                 sg_active;
    logic                 dirty;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.nv_write = 1'b0;
        sel = pws_pkg::SEL_NONE;
        raw = {~step_in, ~down_contact_in, ~up_contact_in};
        served = '0;
        qual = '0;
        sg_step = 1'b0;
        go_up = 1'b0;
        sg_active = 1'b0;
        dirty = 1'b0;
        if (!st.booted) begin
            // restore and strap capture happen right after reset release
            next_st.booted  = 1'b1;
            next_st.wiper   = nv_data_in;
            next_st.stored  = nv_data_in;
            next_st.single  = down_strap_in;
        end else begin
            // fixed order: step input, then up, then down
            if (st.pend[pws_pkg::CH_STEP]) begin
                sel = pws_pkg::SEL_STEP;
                served[pws_pkg::CH_STEP] = 1'b1;
            end else if (st.pend[pws_pkg::CH_UP]) begin
                sel = pws_pkg::SEL_UP;
                served[pws_pkg::CH_UP] = 1'b1;
            end else if (st.pend[pws_pkg::CH_DOWN]) begin
                sel = pws_pkg::SEL_DOWN;
                served[pws_pkg::CH_DOWN] = 1'b1;
            end
            next_st.pend = st.pend & ~served;

            // per-input qualification; a new request below wins a clear
            for (int i = 0; i < pws_pkg::NCH; i++) begin
                qual = (i == pws_pkg::CH_STEP) ?
                       pws_pkg::CNT_W'(pws_pkg::DIGITAL_CYC) :
                       pws_pkg::CNT_W'(CONTACT_CYC);
                if (raw[i] == st.pressed[i]) begin
                    next_st.lvl_cnt[i] = '0;
                end else if (st.lvl_cnt[i] >= qual - 1) begin
                    // short highs never reach here, so pulses merge
                    next_st.lvl_cnt[i] = '0;
                    next_st.pressed[i] = raw[i];
                    if (raw[i]) begin
                        next_st.pend[i]     = 1'b1;
                        next_st.hold_cnt[i] = '0;
                    end
                end else begin
                    next_st.lvl_cnt[i] = st.lvl_cnt[i] + 1'b1;
                end
                if (st.pressed[i] && next_st.pressed[i]) begin
                    if (st.hold_cnt[i] >= pws_pkg::CNT_W'(HOLD_CYC - 1)) begin
                        next_st.pend[i]     = 1'b1;
                        next_st.hold_cnt[i] =
                            pws_pkg::CNT_W'(HOLD_CYC - REPEAT_CYC);
                    end else begin
                        next_st.hold_cnt[i] = st.hold_cnt[i] + 1'b1;
                    end
                end
            end
            if (st.single) begin
                next_st.pend[pws_pkg::CH_DOWN] = 1'b0;
            end

            // one-input steps follow the shared direction
            sg_step = (sel == pws_pkg::SEL_STEP) ||
                      (sel == pws_pkg::SEL_UP && st.single);
            go_up = sg_step ? st.dir_up : (sel == pws_pkg::SEL_UP);
            if (sel != pws_pkg::SEL_NONE) begin
                if (go_up && st.wiper != pws_pkg::WIPER_MAX) begin
                    next_st.wiper = st.wiper + 1'b1;
                end else if (!go_up && st.wiper != pws_pkg::WIPER_MIN) begin
                    next_st.wiper = st.wiper - 1'b1;
                end
            end
            // dual-button steps leave direction alone, so ends just stick
            if (sg_step) begin
                next_st.moved = 1'b1;
                if (next_st.wiper == pws_pkg::WIPER_MIN) begin
                    next_st.dir_up = 1'b1;
                    next_st.moved  = 1'b0;
                end else if (next_st.wiper == pws_pkg::WIPER_MAX) begin
                    next_st.dir_up = 1'b0;
                    next_st.moved  = 1'b0;
                end
            end

            // inactivity reversal; counter parks at its limit
            sg_active = st.pressed[pws_pkg::CH_STEP] ||
                        (st.single && st.pressed[pws_pkg::CH_UP]);
            if (sg_active) begin
                next_st.idle_cnt = '0;
            end else if (st.idle_cnt >= pws_pkg::CNT_W'(IDLE_CYC - 1)) begin
                if (st.moved && !sg_step) begin
                    next_st.dir_up = ~st.dir_up;
                    next_st.moved  = 1'b0;
                end
            end else begin
                next_st.idle_cnt = st.idle_cnt + 1'b1;
            end

            // store scheduling; bit 3 filter limits cell wear
            dirty = st.first_done ?
                    (st.wiper[pws_pkg::STORE_BIT] !=
                     st.stored[pws_pkg::STORE_BIT]) :
                    (st.wiper != st.stored);
            if (next_st.wiper != st.wiper) begin
                next_st.stable_cnt = '0;
            end else if (st.stable_cnt < pws_pkg::CNT_W'(STORE_CYC - 1)) begin
                next_st.stable_cnt = st.stable_cnt + 1'b1;
            end else if (dirty) begin
                next_st.nv_write   = 1'b1;
                next_st.nv_data    = st.wiper;
                next_st.stored     = st.wiper;
                next_st.first_done = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st        <= '0;
            st.dir_up <= 1'b1;
            st.wiper  <= pws_pkg::WIPER_RST;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign wiper_out       = st.wiper;
    assign single_mode_out = st.single;
    assign dir_up_out      = st.dir_up;
    assign nv_write_out    = st.nv_write;
    assign nv_data_out     = st.nv_data;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence up_press_s;
        $rose(st.pressed[pws_pkg::CH_UP]);
    endsequence

    sequence step_press_s;
        $rose(st.pressed[pws_pkg::CH_STEP]);
    endsequence

    sequence top_reached_s;
        st.single && st.wiper == pws_pkg::WIPER_MAX &&
        $past(st.wiper) == 6'h3E;
    endsequence

    wiper_one_step_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ($past(st.booted) && st.wiper != $past(st.wiper)) |->
        (st.wiper - $past(st.wiper) == 6'h01 ||
         $past(st.wiper) - st.wiper == 6'h01))
        else $error("wiper moved by more than one tap");

    press_low_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        up_press_s |-> $past(!up_contact_in))
        else $error("up press without low input");

    press_request_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        step_press_s |-> st.pend[pws_pkg::CH_STEP])
        else $error("qualified press gave no request");

    no_wrap_a: assert property (
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (st.booted && st.wiper == pws_pkg::WIPER_MIN) |=>
        st.wiper != pws_pkg::WIPER_MAX)
        else $error("wiper wrapped around");

    down_ignored_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st.booted && st.single) |-> !st.pend[pws_pkg::CH_DOWN])
        else $error("down contact active in one-button mode");

    end_hold_a: assert property (
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (st.booted && !st.single && sel == pws_pkg::SEL_UP &&
         st.wiper == pws_pkg::WIPER_MAX) |=> st.wiper == pws_pkg::WIPER_MAX)
        else $error("wiper left top end on up request");

    end_reverse_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        top_reached_s |-> !st.dir_up)
        else $error("direction not reversed at top end");

    store_data_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        st.nv_write |-> (st.nv_data == st.wiper &&
                         $past(st.wiper) == st.wiper))
        else $error("store of unstable or wrong wiper");

    store_bit_a: assert property (
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (st.nv_write && $past(st.first_done)) |->
        $past(st.stored[pws_pkg::STORE_BIT]) != st.nv_data[pws_pkg::STORE_BIT])
        else $error("later store without bit 3 change");

    sequence dual_up_s;
        ce_in && !st.single && sel == pws_pkg::SEL_UP &&
        st.wiper != pws_pkg::WIPER_MAX;
    endsequence

    sequence dual_down_s;
        ce_in && !st.single && sel == pws_pkg::SEL_DOWN &&
        st.wiper != pws_pkg::WIPER_MIN;
    endsequence

    up_step_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        dual_up_s |=> st.wiper == $past(st.wiper) + 6'h01)
        else $error("up contact did not step up");

    down_step_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        dual_down_s |=> st.wiper == $past(st.wiper) - 6'h01)
        else $error("down contact did not step down");

    mode_latch_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $past(st.booted) |-> st.single == $past(st.single))
        else $error("mode changed after power-up");

    restore_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(st.booted) |-> st.wiper == $past(nv_data_in))
        else $error("wiper not restored at power-up");

    release_high_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $fell(st.pressed[pws_pkg::CH_UP]) |-> $past(up_contact_in))
        else $error("up release without high input");

    nv_pulse_a: assert property (
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        st.nv_write |=> !st.nv_write)
        else $error("store pulse longer than one cycle");

endmodule : pws_stepper

// ===== pws_buttons.sv
/*
  Far-side model: two contacts and a processor step line, pulled up.
  Assumes the bench calls pulse() and nothing else drives the lines.
*/
`timescale 1ns/1ps
module pws_buttons (
    input  wire logic clk_in,
    output logic      up_line_out,
    output logic      down_line_out,
    output logic      step_line_out
);
    // released lines read high through the pull-ups
    initial begin
        up_line_out   = 1'b1;
        down_line_out = 1'b1;
        step_line_out = 1'b1;
    end

    function automatic void set_line(input int ch, input logic v);
        case (ch)
            0: up_line_out = v;
            1: down_line_out = v;
            default: step_line_out = v;
        endcase
    endfunction : set_line

    // hi shorter than the release time merges presses on purpose
    task automatic pulse(input int ch, input int lo, input int hi);
        @(negedge clk_in);
        set_line(ch, 1'b0);
        repeat (lo) @(negedge clk_in);
        set_line(ch, 1'b1);
        repeat (hi) @(negedge clk_in);
    endtask : pulse
endmodule : pws_buttons

// ===== testbench.sv
/*
  Self-checking bench for pws_stepper with shortened timing.
  Assumes pws_buttons stands for the contacts and the processor.
*/
`timescale 1ns/1ps
module testbench;
    localparam int CC = 8;
    localparam int HC = 600;
    localparam int RC = 20;
    localparam int IC = 700;
    localparam int SC = 900;
    logic        clk_in   = 1'b0;
    logic        rst_in   = 1'b1;
    logic        strap    = 1'b0;
    logic        nv_watch = 1'b0;
    logic        ce       = 1'b1;
    logic [5:0]  nv       = 6'h00;
    logic        up_l, dn_l, st_l, single, dir_up, nv_wr;
    logic [5:0]  wiper, nv_out, prev;
    logic [5:0]  wq[$];
    logic [5:0]  nq[$];
    int          mismatches = 0;
    int          checked    = 0;
    logic [31:0] seed       = 32'hC1B39E63;

    always #2 clk_in = ~clk_in;

    pws_buttons btn (.clk_in(clk_in), .up_line_out(up_l),
        .down_line_out(dn_l), .step_line_out(st_l));

    pws_stepper #(.CONTACT_CYC(CC), .HOLD_CYC(HC), .REPEAT_CYC(RC),
        .IDLE_CYC(IC), .STORE_CYC(SC)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
        .up_contact_in(up_l), .down_contact_in(dn_l), .step_in(st_l),
        .down_strap_in(strap), .nv_data_in(nv), .wiper_out(wiper),
        .single_mode_out(single), .dir_up_out(dir_up),
        .nv_write_out(nv_wr), .nv_data_out(nv_out));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // ------------------------------------------------------------------
    // result watcher: every wiper move, or store while nv_watch is set, takes the oldest note
    // ------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (rst_in) begin
            prev <= wiper;
        end else if (wiper !== prev) begin
            prev <= wiper;
            if (wq.size() == 0) cmp(wiper, prev);
            else cmp(wiper, wq.pop_front());
        end
        if (nv_watch && nv_wr === 1'b1) begin
            if (nq.size() == 0) cmp({5'h00, nv_wr}, 6'h00);
            else cmp(nv_out, nq.pop_front());
        end
    end

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic do_reset(input logic s, input logic [5:0] v);
        @(negedge clk_in);
        rst_in = 1'b1;
        strap = s;
        nv = v;
        repeat (16) @(negedge clk_in);
        if (v != 6'h00) wq.push_back(v);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        cmp({5'h00, single}, {5'h00, s});
        cmp({5'h00, dir_up}, 6'h01);
    endtask : do_reset

    // contact presses get a random legal width, step line 260 cycles
    task automatic go(input int ch, input logic [5:0] v, input logic mv);
        if (mv) wq.push_back(v);
        if (ch == 2) btn.pulse(ch, 260, 260);
        else btn.pulse(ch, 10 + int'(xs() % 20), 12);
    endtask : go

    task automatic end_test(input string name);
        repeat (20) @(negedge clk_in);
        cmp(6'(wq.size() + nq.size()), 6'h00);
        wq.delete();
        nq.delete();
        $display("test %s done", name);
    endtask : end_test

    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [5:0] r;
        do_reset(1'b0, 6'h10 + 6'(xs() % 32));
        r = nv;
        go(0, r + 6'h01, 1'b1);
        go(1, r, 1'b1);
        wq.push_back(r + 6'h01);
        btn.pulse(0, 10, 3);
        btn.pulse(0, 10, 12);
        go(1, r, 1'b1);
        for (int i = 1; i < 4; i++) wq.push_back(r + 6'(i));
        btn.pulse(0, HC + 30, 12);
        go(2, r + 6'h04, 1'b1);
        end_test("dual");
        for (int i = 0; i < 2; i++) begin
            do_reset(1'b0, (i == 0) ? 6'h3E : 6'h01);
            go(i, (i == 0) ? 6'h3F : 6'h00, 1'b1);
            go(i, 6'h00, 1'b0);
            go(1 - i, (i == 0) ? 6'h3E : 6'h01, 1'b1);
        end
        end_test("ends");
        do_reset(1'b1, 6'h3E);
        go(1, 6'h00, 1'b0);
        go(0, 6'h3F, 1'b1);
        cmp({5'h00, dir_up}, 6'h00);
        go(0, 6'h3E, 1'b1);
        repeat (IC + 50) @(negedge clk_in);
        cmp({5'h00, dir_up}, 6'h01);
        go(0, 6'h3F, 1'b1);
        go(2, 6'h3E, 1'b1);
        end_test("single");
        do_reset(1'b0, 6'h14);
        nv_watch = 1'b1;
        nq.push_back(6'h15);
        go(0, 6'h15, 1'b1);
        repeat (SC + 50) @(negedge clk_in);
        go(0, 6'h16, 1'b1);
        repeat (SC + 50) @(negedge clk_in);
        nq.push_back(6'h18);
        go(0, 6'h17, 1'b1);
        go(0, 6'h18, 1'b1);
        repeat (SC + 50) @(negedge clk_in);
        nv_watch = 1'b0;
        end_test("store");
        // a press while the enable is low must leave every state alone
        ce = 1'b0;
        go(0, 6'h00, 1'b0);
        ce = 1'b1;
        end_test("enable");
        tally_and_finish();
    end
endmodule : testbench
